// ===== src/rldac_top.sv
// Summary of operation
// - converter works only when on bit set
// - five-bit level code picks 32 levels
// - out equals bottom plus span times code/32
// - pin enables connect level to pins
// - selected pin loses digital driver, pull-up, input
// - source pick: 1 external pin, 0 supply
// - ladder bottom always tied to ground
// - sleep wake leaves control register unchanged
// - reset clears all control and level bits
// - unimplemented bits read as zero
// - level offered to comparator, converter, pins
`timescale 1ns/1ps
`default_nettype none
module rldac_top
	import rldac_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// sleep status, not used by any block logic
	input wire logic device_asleep,
	// ladder controls
	output logic converter_on,
	output logic positive_source_pick,
	output logic ladder_bottom_is_ground,
	output logic [RLDAC_LEVEL_W-1:0] ladder_level_code,
	output logic [RLDAC_LEVEL_W-1:0] ladder_tap_select,
	output logic ladder_powered,
	// routing of ladder_level_out
	output logic route_to_comparator,
	output logic route_to_adc,
	output logic ref_out_pin_one,
	output logic ref_out_pin_two,
	output logic pin_one_digital_override,
	output logic pin_two_digital_override
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] control; // ref_converter_control
		logic [7:0] level; // ref_converter_level
		logic [RLDAC_ADDR_W-1:0] awaddr; // latched write address
		logic aw_held; // address taken
		logic [7:0] wdata; // latched low byte
		logic wstrb0; // low lane strobe
		logic w_held; // data taken
		logic bvalid; // write response pending
		logic [1:0] bresp; // write response code
		logic rvalid; // read data pending
		logic [1:0] rresp; // read response code
		logic [7:0] rdata; // read byte
	} rldac_state_s;

	rldac_state_s st_r;
	rldac_state_s st_nxt;

	// unused protection and upper address bits
	logic unused_ok;
	assign unused_ok = ^{s_axi_awprot, s_axi_arprot, device_asleep,
		s_axi_awaddr[31:RLDAC_ADDR_W], s_axi_araddr[31:RLDAC_ADDR_W],
		s_axi_wdata[31:8], s_axi_wstrb[3:1]};

	// ---------------------------------------------------------------
	// handshakes
	// ---------------------------------------------------------------
	assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
	assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
	assign s_axi_arready = !st_r.rvalid;

	// combined write request once both halves are in
	logic [RLDAC_ADDR_W-1:0] wr_addr;
	logic [7:0] wr_byte;
	logic wr_lane;
	logic wr_go;
	logic rd_go;
	always_comb
	begin
		wr_addr = st_r.aw_held ? st_r.awaddr : s_axi_awaddr[RLDAC_ADDR_W-1:0];
		wr_byte = st_r.w_held ? st_r.wdata : s_axi_wdata[7:0];
		wr_lane = st_r.w_held ? st_r.wstrb0 : s_axi_wstrb[0];
		wr_go = (st_r.aw_held || (s_axi_awvalid && s_axi_awready)) &&
			(st_r.w_held || (s_axi_wvalid && s_axi_wready)) &&
			!st_r.bvalid;
		rd_go = s_axi_arvalid && s_axi_arready;
	end

	// ---------------------------------------------------------------
	// next state: bus slave and register file
	// ---------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		// hold halves that arrive alone
		if (s_axi_awvalid && s_axi_awready && !wr_go)
		begin
			st_nxt.aw_held = 1'b1;
			st_nxt.awaddr = s_axi_awaddr[RLDAC_ADDR_W-1:0];
		end
		if (s_axi_wvalid && s_axi_wready && !wr_go)
		begin
			st_nxt.w_held = 1'b1;
			st_nxt.wdata = s_axi_wdata[7:0];
			st_nxt.wstrb0 = s_axi_wstrb[0];
		end
		// retire a write response
		if (st_r.bvalid && s_axi_bready)
			st_nxt.bvalid = 1'b0;
		// perform a write
		if (wr_go)
		begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RLDAC_RESP_OKAY;
			// sleep and wake never touch the stored bytes
			if (wr_addr == RLDAC_OFS_CONTROL)
			begin
				if (wr_lane)
					st_nxt.control = wr_byte & RLDAC_CONTROL_MASK;
			end
			else if (wr_addr == RLDAC_OFS_LEVEL)
			begin
				if (wr_lane)
					st_nxt.level = wr_byte & RLDAC_LEVEL_MASK;
			end
			else
				st_nxt.bresp = RLDAC_RESP_SLVERR; // unmapped
		end
		// retire read data
		if (st_r.rvalid && s_axi_rready)
			st_nxt.rvalid = 1'b0;
		// perform a read
		if (rd_go)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RLDAC_RESP_OKAY;
			if (s_axi_araddr[RLDAC_ADDR_W-1:0] == RLDAC_OFS_CONTROL)
				st_nxt.rdata = st_r.control & RLDAC_CONTROL_MASK;
			else if (s_axi_araddr[RLDAC_ADDR_W-1:0] == RLDAC_OFS_LEVEL)
				st_nxt.rdata = st_r.level & RLDAC_LEVEL_MASK;
			else
			begin
				st_nxt.rdata = 8'h00;
				st_nxt.rresp = RLDAC_RESP_SLVERR;
			end
		end
	end

	// ---------------------------------------------------------------
	// state register; every reset clears the settings
	// ---------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= '0;
			st_r.control <= RLDAC_CONTROL_RST;
			st_r.level <= RLDAC_LEVEL_RST;
		end
		else
			st_r <= st_nxt;
	end

	// bus outputs
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rresp = st_r.rresp;
	assign s_axi_rdata = {24'h000000, st_r.rdata};

	// ---------------------------------------------------------------
	// settings to the ladder, live from the edge after the write
	// ---------------------------------------------------------------
	assign converter_on = st_r.control[RLDAC_BIT_ON];
	assign positive_source_pick = st_r.control[RLDAC_BIT_PSS];
	assign ladder_bottom_is_ground = 1'b1;
	assign ladder_level_code = st_r.level[RLDAC_LEVEL_W-1:0];
	// the level is offered internally whenever the ladder runs
	assign route_to_comparator = ladder_powered;
	assign route_to_adc = ladder_powered;

	// tap selector
	rldac_ladder_model #(.LEVEL_W(RLDAC_LEVEL_W)) u_ladder
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.converter_on(converter_on),
		.ladder_level_code(ladder_level_code),
		.tap_select(ladder_tap_select),
		.ladder_powered(ladder_powered)
	);

	// pin one
	rldac_pin_override u_pin_one
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.drive_on(st_r.control[RLDAC_BIT_OE1]),
		.analog_connect(ref_out_pin_one),
		.digital_override(pin_one_digital_override)
	);

	// pin two
	rldac_pin_override u_pin_two
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.drive_on(st_r.control[RLDAC_BIT_OE2]),
		.analog_connect(ref_out_pin_two),
		.digital_override(pin_two_digital_override)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	reset_clear_a: assert property (@(posedge aclk)
		!aresetn |=> st_r.control == 8'h00 && st_r.level == 8'h00)
		else $error("reset did not clear settings");
	unimpl_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> (s_axi_rdata & 32'hffffff4b) == 32'h0 ||
		(s_axi_rdata & 32'hffffffe0) == 32'h0)
		else $error("unimplemented bits read nonzero");
	write_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && wr_lane && wr_addr == RLDAC_OFS_CONTROL |=>
		converter_on == $past(wr_byte[RLDAC_BIT_ON]))
		else $error("enable not applied next edge");
	level_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && wr_lane && wr_addr == RLDAC_OFS_LEVEL |=>
		ladder_level_code == $past(wr_byte[4:0]))
		else $error("level not applied next edge");
	sleep_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!wr_go |=> $stable(st_r.control))
		else $error("control changed without a write");
	bottom_gnd_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ladder_bottom_is_ground)
		else $error("bottom source not ground");
	pss_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
		positive_source_pick == st_r.control[RLDAC_BIT_PSS])
		else $error("source pick mismatch");
	write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go |=> s_axi_bvalid)
		else $error("no write response");
	read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_go |=> s_axi_rvalid)
		else $error("no read response");
	route_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
		route_to_comparator == ladder_powered)
		else $error("comparator route wrong");
	route_adc_a: assert property (@(posedge aclk) disable iff (!aresetn)
		route_to_adc == ladder_powered)
		else $error("converter route wrong");
	level_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!wr_go |=> $stable(st_r.level))
		else $error("level changed without a write");
	reset_outs_a: assert property (@(posedge aclk)
		!aresetn |=> !converter_on && !ref_out_pin_one &&
		!ref_out_pin_two && ladder_level_code == 5'h00)
		else $error("reset left outputs live");
	ctl_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_go && s_axi_araddr[RLDAC_ADDR_W-1:0] == RLDAC_OFS_CONTROL |=>
		(s_axi_rdata[7:0] & ~RLDAC_CONTROL_MASK) == 8'h00)
		else $error("control read shows unused bits");
	lvl_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_go && s_axi_araddr[RLDAC_ADDR_W-1:0] == RLDAC_OFS_LEVEL |=>
		(s_axi_rdata[7:0] & ~RLDAC_LEVEL_MASK) == 8'h00)
		else $error("level read shows unused bits");

	cov_enable_c: cover property (@(posedge aclk) disable iff (!aresetn)
		$rose(converter_on));
	cov_pin_one_c: cover property (@(posedge aclk) disable iff (!aresetn)
		$rose(ref_out_pin_one));
	cov_full_level_c: cover property (@(posedge aclk) disable iff (!aresetn)
		ladder_level_code == 5'h1f && converter_on);
	cov_unmapped_c: cover property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && s_axi_rresp == RLDAC_RESP_SLVERR);

endmodule : rldac_top
`default_nettype wire

// ===== src/rldac_pkg.sv
package rldac_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [3:0] RLDAC_OFS_CONTROL = 4'h0; // control word
	localparam logic [3:0] RLDAC_OFS_LEVEL = 4'h4; // level word
	localparam int RLDAC_ADDR_W = 4; // decoded address bits

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int RLDAC_BIT_ON = 7; // converter_on
	localparam int RLDAC_BIT_OE1 = 5; // pin_one_drive_on
	localparam int RLDAC_BIT_OE2 = 4; // pin_two_drive_on
	localparam int RLDAC_BIT_PSS = 2; // positive_source_pick
	localparam int RLDAC_LEVEL_W = 5; // ladder_level_code width

	// ---------------------------------------------------------------
	// masks and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RLDAC_CONTROL_MASK = 8'hb4; // implemented bits
	localparam logic [7:0] RLDAC_LEVEL_MASK = 8'h1f; // implemented bits
	localparam logic [7:0] RLDAC_CONTROL_RST = 8'h00; // reset value
	localparam logic [7:0] RLDAC_LEVEL_RST = 8'h00; // reset value

	// ---------------------------------------------------------------
	// axi response codes
	// ---------------------------------------------------------------
	localparam logic [1:0] RLDAC_RESP_OKAY = 2'h0; // okay
	localparam logic [1:0] RLDAC_RESP_SLVERR = 2'h2; // unmapped

endpackage : rldac_pkg

// ===== src/rldac_pin_override.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// one output pin: analog hookup and digital override
// ---------------------------------------------------------------
module rldac_pin_override
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic drive_on,
	output logic analog_connect,
	output logic digital_override
);

	// state of the pin switch
	typedef struct packed {
		logic conn; // level routed to the pin
	} rldac_pin_s;

	rldac_pin_s st_r;
	rldac_pin_s st_nxt;

	// ---------------------------------------------------------------
	// pin select follows the control bit one edge later, two edges after the write
	// ---------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.conn = drive_on;
	end

	// register the switch state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// analog switch and buffer, pull-up and input detector override
	assign analog_connect = st_r.conn;
	assign digital_override = st_r.conn;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	pin_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		drive_on |=> analog_connect)
		else $error("pin did not connect");
	pin_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!drive_on |=> !analog_connect)
		else $error("pin did not disconnect");
	override_tie_a: assert property (@(posedge aclk) disable iff (!aresetn)
		digital_override == analog_connect)
		else $error("override not with connection");

endmodule : rldac_pin_override
`default_nettype wire

// ===== src/rldac_ladder_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// digital image of the ladder tap selection
// ---------------------------------------------------------------
module rldac_ladder_model
	import rldac_pkg::*;
#(
	parameter int LEVEL_W = RLDAC_LEVEL_W
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic converter_on,
	input wire logic [LEVEL_W-1:0] ladder_level_code,
	output logic [LEVEL_W-1:0] tap_select,
	output logic ladder_powered
);

	// refuse widths the tap decoder cannot serve
	if (LEVEL_W != RLDAC_LEVEL_W)
	begin : g_bad_width
		$error("level width must be five");
	end

	// state of the tap selector
	typedef struct packed {
		logic [LEVEL_W-1:0] tap;
		logic pwr;
	} rldac_tap_s;

	rldac_tap_s st_r;
	rldac_tap_s st_nxt;

	// ---------------------------------------------------------------
	// tap: out = bottom + (top - bottom) * code / 2^5
	// ---------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.pwr = converter_on;
		// ladder unpowered forces the lowest tap
		if (converter_on)
			st_nxt.tap = ladder_level_code;
		else
			st_nxt.tap = '0;
	end

	// register the selector
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tap_select = st_r.tap;
	assign ladder_powered = st_r.pwr;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	tap_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
		converter_on |=> tap_select == $past(ladder_level_code))
		else $error("tap not following code");
	off_tap_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!ladder_powered |-> tap_select == '0)
		else $error("tap live while off");

endmodule : rldac_ladder_model
`default_nettype wire

// ===== testbench/test_rldac_top.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// bench for the ladder reference control block
// ---------------------------------------------------------------
module test_rldac_top
	import rldac_pkg::*;
;
	// ---------------------------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------------------------
	logic aclk; // 50 mhz system clock
	logic aresetn; // sync reset, active low
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [2:0] s_axi_awprot, s_axi_arprot; // tied, ignored by block
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic device_asleep; // sleep status input
	logic converter_on, positive_source_pick, ladder_bottom_is_ground;
	logic [RLDAC_LEVEL_W-1:0] ladder_level_code, ladder_tap_select;
	logic ladder_powered, route_to_comparator, route_to_adc;
	logic ref_out_pin_one, ref_out_pin_two;
	logic pin_one_digital_override, pin_two_digital_override;
	int num_errors = 0; // mismatches seen
	int n_compared = 0; // comparisons made
	logic [31:0] d; // last read data
	logic [1:0] r; // last response code
	logic [7:0] ctl_tab [4] = '{8'h20, 8'h10, 8'h04, 8'h80}; // single bits

	// ---------------------------------------------------------------
	// design under test
	// ---------------------------------------------------------------
	rldac_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .device_asleep, .converter_on,
		.positive_source_pick, .ladder_bottom_is_ground,
		.ladder_level_code, .ladder_tap_select, .ladder_powered,
		.route_to_comparator, .route_to_adc, .ref_out_pin_one,
		.ref_out_pin_two, .pin_one_digital_override,
		.pin_two_digital_override);

	// clock: toggles every half period
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// time-zero values for every input
	initial
	begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awprot, s_axi_arprot, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, device_asleep} = '0;
	end

	// ---------------------------------------------------------------
	// helper tasks
	// ---------------------------------------------------------------
	// compare seen against expected, count and report
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// hold reset low for 20 cycles
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : do_reset

	// one write: address and data offered together
	task automatic wr(input logic [3:0] a, input logic [7:0] v,
		input logic [3:0] st, output logic [1:0] resp);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= {28'h0000000, a};
		s_axi_wdata <= {24'h000000, v};
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			// release each channel once taken
			if (!aw_ok && s_axi_awvalid && s_axi_awready)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wvalid && s_axi_wready)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1)
			@(posedge aclk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	// one read: address then wait for data
	task automatic rd(input logic [3:0] a, output logic [31:0] v,
		output logic [1:0] resp);
		s_axi_araddr <= {28'h0000000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		while (s_axi_arready !== 1'b1)
			@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		while (s_axi_rvalid !== 1'b1)
			@(posedge aclk);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	// check all ladder and pin outputs once settled
	task automatic outs(input logic on, input logic ps,
		input logic [4:0] c, input logic p1, input logic p2);
		repeat (2) @(posedge aclk);
		#1;
		chk("converter_on", converter_on, on);
		chk("ladder_powered", ladder_powered, on);
		chk("source_pick", positive_source_pick, ps);
		chk("bottom_ground", ladder_bottom_is_ground, 1);
		chk("level_code", ladder_level_code, c);
		chk("tap_select", ladder_tap_select, on ? c : 5'h00);
		chk("route_cmp", route_to_comparator, on);
		chk("route_adc", route_to_adc, on);
		chk("pin_one", ref_out_pin_one, p1);
		chk("pin_two", ref_out_pin_two, p2);
		chk("ovr_one", pin_one_digital_override, p1);
		chk("ovr_two", pin_two_digital_override, p2);
		@(posedge aclk);
	endtask : outs

	// verdict and end of run
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial
	begin
		do_reset();
		// reset values of both registers and outputs
		rd(RLDAC_OFS_CONTROL, d, r);
		chk("ctl_reset", d, 32'h00000000);
		rd(RLDAC_OFS_LEVEL, d, r);
		chk("lvl_reset", d, 32'h00000000);
		outs(1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
		$display("test reset done");
		// all ones: unimplemented bits masked
		wr(RLDAC_OFS_CONTROL, 8'hff, 4'hf, r);
		chk("wr_resp", r, RLDAC_RESP_OKAY);
		chk("on_after_wr", converter_on, 1'b1);
		wr(RLDAC_OFS_LEVEL, 8'hff, 4'hf, r);
		rd(RLDAC_OFS_CONTROL, d, r);
		chk("ctl_mask", d, 32'h000000b4);
		rd(RLDAC_OFS_LEVEL, d, r);
		chk("lvl_mask", d, 32'h0000001f);
		outs(1'b1, 1'b1, 5'h1f, 1'b1, 1'b1);
		// each control bit alone
		foreach (ctl_tab[k])
		begin
			wr(RLDAC_OFS_CONTROL, ctl_tab[k], 4'hf, r);
			outs(ctl_tab[k][7], ctl_tab[k][2], 5'h1f, ctl_tab[k][5],
				ctl_tab[k][4]);
		end
		$display("test control bits done");
		// sweep all 32 level codes, converter on
		for (int i = 0; i < 32; i++)
		begin
			wr(RLDAC_OFS_LEVEL, i[7:0], 4'hf, r);
			outs(1'b1, 1'b0, i[4:0], 1'b0, 1'b0);
		end
		$display("test level sweep done");
		// strobe off: okay but nothing stored
		wr(RLDAC_OFS_LEVEL, 8'h0a, 4'h0, r);
		chk("nostrobe_resp", r, RLDAC_RESP_OKAY);
		rd(RLDAC_OFS_LEVEL, d, r);
		chk("nostrobe_keep", d, 32'h0000001f);
		// unmapped places
		wr(4'h8, 8'h55, 4'hf, r);
		chk("unmap_wr", r, RLDAC_RESP_SLVERR);
		rd(4'hc, d, r);
		chk("unmap_rresp", r, RLDAC_RESP_SLVERR);
		chk("unmap_rdata", d, 32'h00000000);
		$display("test access kinds done");
		// enable dropped before sleep, pins and source kept
		wr(RLDAC_OFS_CONTROL, 8'h34, 4'hf, r);
		device_asleep <= 1'b1;
		repeat (10) @(posedge aclk);
		device_asleep <= 1'b0;
		@(posedge aclk);
		rd(RLDAC_OFS_CONTROL, d, r);
		chk("ctl_wake", d, 32'h00000034);
		outs(1'b0, 1'b1, 5'h1f, 1'b1, 1'b1);
		$display("test sleep done");
		// second reset in mid-run clears everything
		do_reset();
		rd(RLDAC_OFS_CONTROL, d, r);
		chk("ctl_rerst", d, 32'h00000000);
		rd(RLDAC_OFS_LEVEL, d, r);
		chk("lvl_rerst", d, 32'h00000000);
		outs(1'b0, 1'b0, 5'h00, 1'b0, 1'b0);
		$display("test second reset done");
		wrap_up();
	end

	// watchdog: run needs under 2000 cycles
	initial
	begin
		#400000;
		num_errors++;
		$display("watchdog expired");
		wrap_up();
	end

endmodule : test_rldac_top
`default_nettype wire
